// ---- hw/odt_control.sv ----
// On-die termination control for the data, strobe and mask pads
`timescale 1ns/10ps
module odt_control
  import odt_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Link pins from the controller
  input wire logic ck_link,
  input wire logic odt_pin,
  // Configuration from the mode registers
  input wire logic [1:0] org,
  input wire logic [13:0] emr1,
  input wire logic [13:0] mr,
  input wire power_mode_type pmode,
  // Pad controls
  output term_pins_type term_en,
  output logic [1:0] rtt_sel,
  output logic term_ramping,
  output logic async_mode
);

  typedef struct packed {
    logic [1:0] ck_sync;
    logic [1:0] odt_sync;
    logic ck_prev;
    logic odt_smp;
    logic [3:0] dly;
    logic dly_on;
    logic dly_busy;
    logic [3:0] pd_gap;
    logic in_pd_prev;
    logic [3:0] exit_gap;
    phase_type phase;
    logic async_r;
    term_pins_type term_en;
    logic [1:0] rtt_sel;
  } ctl_state_type;

  ctl_state_type st_r;
  ctl_state_type st_nxt;

  logic ck_rise;
  logic in_pd;
  logic slow_pd;
  logic want_async;
  logic odt_req;
  logic rtt_enabled;
  logic ramp_load;
  logic [3:0] ramp_val;
  logic ramp_done;
  term_pins_type mask;

  odt_ramp_timer u_ramp (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .load(ramp_load),
    .load_val(ramp_val),
    .expired(ramp_done)
  );

  // Only the second flop of each synchroniser is looked at
  assign ck_rise = st_r.ck_sync[1] & ~st_r.ck_prev;
  assign in_pd = pmode.active_pd | pmode.precharge_pd;
  assign slow_pd = (pmode.active_pd & mr[MR_PD_SLOW_POS]) | pmode.precharge_pd;
  // Spacing windows around power-down force the slow path; the controller is told via async_mode
  // The entry window only counts once power-down has begun, so plain active mode stays synchronous
  assign want_async = ~pmode.dll_on | slow_pd | (in_pd & (st_r.pd_gap != 4'h0)) | (st_r.exit_gap != 4'h0);
  assign rtt_enabled = emr1[EMR_RTT_HI_POS] | emr1[EMR_RTT_LO_POS];
  assign odt_req = st_r.odt_sync[1] & rtt_enabled & ~pmode.self_refresh;
  assign mask = pin_mask(org, emr1);

  always_comb
  begin
    st_nxt = st_r;
    ramp_load = 1'b0;
    ramp_val = 4'h0;
    st_nxt.ck_sync = {st_r.ck_sync[0], ck_link};
    st_nxt.odt_sync = {st_r.odt_sync[0], odt_pin};
    st_nxt.ck_prev = st_r.ck_sync[1];
    st_nxt.async_r = want_async;
    st_nxt.rtt_sel = {emr1[EMR_RTT_HI_POS], emr1[EMR_RTT_LO_POS]};
    // Track spacing in link cycles before entry; after exit count down a guard
    st_nxt.in_pd_prev = in_pd;
    if (ck_rise)
    begin
      if (st_r.exit_gap != 4'h0)
      begin
        st_nxt.exit_gap = st_r.exit_gap - 4'h1;
      end
      if (st_r.pd_gap != 4'h0)
      begin
        st_nxt.pd_gap = st_r.pd_gap - 4'h1;
      end
    end
    if (st_r.in_pd_prev & ~in_pd)
    begin
      st_nxt.exit_gap = AXPD_CK;
    end
    if (~in_pd & (st_r.odt_smp != odt_req) & ck_rise)
    begin
      st_nxt.pd_gap = ANPD_CK;
    end
    // Synchronous path: sample on link edge and count link cycles
    if (~want_async)
    begin
      if (ck_rise)
      begin
        st_nxt.odt_smp = odt_req;
        if (st_r.dly_busy)
        begin
          if (st_r.dly == 4'h1)
          begin
            st_nxt.dly_busy = 1'b0;
            ramp_load = 1'b1;
            st_nxt.phase = st_r.dly_on ? PH_RAMP_ON : PH_RAMP_OFF;
            ramp_val = st_r.dly_on ? AON_MAX_CYC : AOF_MAX_CYC;
          end
          st_nxt.dly = st_r.dly - 4'h1;
        end
        else if (odt_req != st_r.odt_smp)
        begin
          st_nxt.dly_busy = 1'b1;
          st_nxt.dly_on = odt_req;
          st_nxt.dly = odt_req ? AOND_CK : AOFD_CK;
        end
      end
    end
    else if ((odt_req != st_r.odt_smp) && !st_r.dly_busy && (st_r.phase == PH_ON || st_r.phase == PH_OFF))
    begin
      // Asynchronous path: start the ramp at once on a pin change
      st_nxt.odt_smp = odt_req;
      ramp_load = 1'b1;
      st_nxt.phase = odt_req ? PH_RAMP_ON : PH_RAMP_OFF;
      ramp_val = odt_req ? AONPD_MAX_CYC : AOFPD_MAX_CYC;
    end
    else if (st_r.dly_busy)
    begin
      // Pending synchronous delay is abandoned when the path turns asynchronous
      st_nxt.dly_busy = 1'b0;
      st_nxt.odt_smp = ~st_r.dly_on;
    end
    case (st_r.phase)
      PH_RAMP_ON:
      begin
        if (ramp_done)
        begin
          st_nxt.phase = PH_ON;
        end
      end
      PH_RAMP_OFF:
      begin
        if (ramp_done)
        begin
          st_nxt.phase = PH_OFF;
        end
      end
      PH_ON, PH_OFF:
      begin
      end
      default:
      begin
        st_nxt.phase = PH_OFF;
      end
    endcase
    // Pads see termination from the start of turn-on until turn-off completes
    if (((st_nxt.phase == PH_ON) || (st_nxt.phase == PH_RAMP_ON) || (st_nxt.phase == PH_RAMP_OFF)) &&
        rtt_enabled && !pmode.self_refresh)
    begin
      st_nxt.term_en = mask;
    end
    else
    begin
      st_nxt.term_en = '0;
    end
    if (pmode.self_refresh)
    begin
      st_nxt.phase = PH_OFF;
      st_nxt.odt_smp = 1'b0;
      st_nxt.dly_busy = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign term_en = st_r.term_en;
  assign rtt_sel = st_r.rtt_sel;
  assign term_ramping = (st_r.phase == PH_RAMP_ON) || (st_r.phase == PH_RAMP_OFF);
  assign async_mode = st_r.async_r;

  chk_selfref_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(pmode.self_refresh) |-> term_en == '0)
    else $error("termination active in self-refresh");

  chk_disabled_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !$past(rtt_enabled) |-> term_en == '0)
    else $error("termination active while disabled");

  chk_rtt_sel: assert property (@(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> rtt_sel == {$past(emr1[EMR_RTT_HI_POS]), $past(emr1[EMR_RTT_LO_POS])})
    else $error("resistor select does not follow register");

  chk_mask_dqsn: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $past(emr1[EMR_NDQS_DIS_POS]) |-> !term_en.dqs_n && !term_en.udqs_n)
    else $error("complementary strobe terminated while disabled");

  chk_x8_share: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ($past(org) == ORG_X8) |-> !(term_en.rdqs && term_en.dm))
    else $error("shared pin terminated as both mask and strobe");

  chk_rdqsn: assert property (@(posedge clk_sys) disable iff (!rst_n)
    term_en.rdqs_n |-> $past(org) == ORG_X8 && $past(emr1[EMR_RDQS_EN_POS]) && !$past(emr1[EMR_NDQS_DIS_POS]))
    else $error("complementary read strobe wrongly terminated");

  chk_x16_upper: assert property (@(posedge clk_sys) disable iff (!rst_n)
    term_en.udqs |-> $past(org) == ORG_X16 && term_en.udm && term_en.dq)
    else $error("upper byte termination mismatch");

  sequence s_ramp_on;
    st_r.phase == PH_RAMP_ON;
  endsequence

  chk_ramp_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(st_r.phase == PH_RAMP_ON) ##0 s_ramp_on |-> ##[1:18] (st_r.phase != PH_RAMP_ON))
    else $error("turn-on ramp exceeded its window");

  chk_slow_async: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pmode.precharge_pd || !pmode.dll_on) |=> async_mode)
    else $error("asynchronous timing not selected");

  chk_slow_exit: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pmode.active_pd && mr[MR_PD_SLOW_POS]) |=> async_mode)
    else $error("slow-exit power-down kept synchronous timing");

  chk_fast_sync: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (pmode.dll_on && !in_pd && (st_r.exit_gap == 4'h0)) |=> !async_mode)
    else $error("asynchronous timing with the DLL running");

  chk_entry_async: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (in_pd && (st_r.pd_gap != 4'h0)) |=> async_mode)
    else $error("late switch before power-down kept synchronous timing");

  chk_exit_async: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (st_r.in_pd_prev && !in_pd) |-> ##2 async_mode)
    else $error("switch after power-down exit kept synchronous timing");

  sequence s_sync_last;
    ck_rise && !want_async && st_r.dly_busy && (st_r.dly == 4'h1) && !pmode.self_refresh;
  endsequence

  sequence s_async_change;
    want_async && (odt_req != st_r.odt_smp) && !st_r.dly_busy && !pmode.self_refresh;
  endsequence

  chk_sync_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ck_rise && !want_async && !st_r.dly_busy && (odt_req != st_r.odt_smp) && !pmode.self_refresh) |=>
      st_r.dly_busy && (st_r.dly_on == $past(odt_req)) && (st_r.dly == (st_r.dly_on ? AOND_CK : AOFD_CK)))
    else $error("synchronous delay not started on the link edge");

  chk_sync_ramp: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_sync_last |=> term_ramping)
    else $error("synchronous delay ended without a ramp");

  chk_async_start: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_async_change ##0 ((st_r.phase == PH_OFF) || (st_r.phase == PH_ON)) |=> term_ramping)
    else $error("asynchronous switch did not start a ramp");

  chk_term_mask: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (term_en != '0) |-> (term_en == $past(mask)))
    else $error("terminated pins differ from the configured set");

  chk_off_bound: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(st_r.phase == PH_RAMP_OFF) |-> ##[1:18] (st_r.phase != PH_RAMP_OFF))
    else $error("turn-off ramp exceeded its window");

  chk_off_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ((st_r.phase == PH_RAMP_OFF) && $past(rtt_enabled)) |-> (term_en == $past(mask)))
    else $error("termination dropped before the turn-off ramp ended");

  chk_sr_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pmode.self_refresh |=> (st_r.phase == PH_OFF) && !st_r.dly_busy)
    else $error("termination state kept in self-refresh");

endmodule

// ---- hw/odt_pkg.sv ----
// Package with constants and carrier types for the termination control block
package odt_pkg;

  // Organisation codes
  localparam logic [1:0] ORG_X4 = 2'h0;
  localparam logic [1:0] ORG_X8 = 2'h1;
  localparam logic [1:0] ORG_X16 = 2'h2;

  // Extended mode register 1 field positions
  localparam int EMR_RTT_LO_POS = 2;
  localparam int EMR_RTT_HI_POS = 6;
  localparam int EMR_NDQS_DIS_POS = 10;
  localparam int EMR_RDQS_EN_POS = 11;
  // Mode register field position: slow power-down exit
  localparam int MR_PD_SLOW_POS = 12;

  // Reset values
  localparam logic [13:0] EMR1_RESET = 14'h0000;
  localparam logic [13:0] MR_RESET = 14'h0000;

  // Synchronous delays in link clock cycles (turn-on / turn-off)
  localparam logic [3:0] AOND_CK = 4'h2;
  localparam logic [3:0] AOFD_CK = 4'h2;
  // Analog ramp windows in ps, converted to system cycles
  localparam int CLK_SYS_PS = 8000;
  localparam int AON_MIN_PS = 2000;
  localparam int AON_MAX_PS = 9000;
  localparam int AOF_MIN_PS = 2000;
  localparam int AOF_MAX_PS = 9000;
  localparam int AONPD_MIN_PS = 2000;
  localparam int AONPD_MAX_PS = 17000;
  localparam int AOFPD_MIN_PS = 2000;
  localparam int AOFPD_MAX_PS = 17000;
  localparam logic [3:0] AON_MIN_CYC = 4'((AON_MIN_PS + CLK_SYS_PS - 1) / CLK_SYS_PS);
  localparam logic [3:0] AON_MAX_CYC = 4'(AON_MAX_PS / CLK_SYS_PS);
  localparam logic [3:0] AOF_MIN_CYC = 4'((AOF_MIN_PS + CLK_SYS_PS - 1) / CLK_SYS_PS);
  localparam logic [3:0] AOF_MAX_CYC = 4'(AOF_MAX_PS / CLK_SYS_PS);
  localparam logic [3:0] AONPD_MIN_CYC = 4'((AONPD_MIN_PS + CLK_SYS_PS - 1) / CLK_SYS_PS);
  localparam logic [3:0] AONPD_MAX_CYC = 4'(AONPD_MAX_PS / CLK_SYS_PS);
  localparam logic [3:0] AOFPD_MIN_CYC = 4'((AOFPD_MIN_PS + CLK_SYS_PS - 1) / CLK_SYS_PS);
  localparam logic [3:0] AOFPD_MAX_CYC = 4'(AOFPD_MAX_PS / CLK_SYS_PS);
  // Power-down entry / exit spacing in link clock cycles
  localparam logic [3:0] ANPD_CK = 4'h3;
  localparam logic [3:0] AXPD_CK = 4'h8;

  // Operating mode of the device core
  typedef struct packed {
    logic dll_on;
    logic self_refresh;
    logic active_pd;
    logic precharge_pd;
  } power_mode_type;

  // Pins that can carry termination
  typedef struct packed {
    logic dq;
    logic dqs;
    logic dqs_n;
    logic rdqs;
    logic rdqs_n;
    logic dm;
    logic udqs;
    logic udqs_n;
    logic udm;
  } term_pins_type;

  // Termination phase seen on the pads
  typedef enum logic [1:0] {
    PH_OFF = 2'b00,
    PH_RAMP_ON = 2'b01,
    PH_ON = 2'b10,
    PH_RAMP_OFF = 2'b11
  } phase_type;

  // Per-pin termination enable mask from configuration
  function automatic term_pins_type pin_mask(input logic [1:0] org, input logic [13:0] emr1);
    term_pins_type m;
    m = '0;
    m.dq = 1'b1;
    m.dqs = 1'b1;
    m.dqs_n = ~emr1[EMR_NDQS_DIS_POS];
    if (org == ORG_X8)
    begin
      m.rdqs = emr1[EMR_RDQS_EN_POS];
      m.rdqs_n = emr1[EMR_RDQS_EN_POS] & ~emr1[EMR_NDQS_DIS_POS];
      m.dm = ~emr1[EMR_RDQS_EN_POS];
    end
    else
    begin
      m.dm = 1'b1;
    end
    if (org == ORG_X16)
    begin
      m.udqs = 1'b1;
      m.udqs_n = ~emr1[EMR_NDQS_DIS_POS];
      m.udm = 1'b1;
    end
    return m;
  endfunction

endpackage

// ---- hw/odt_ramp_timer.sv ----
// Down counter that paces the analog ramp window of the termination switches
`timescale 1ns/10ps
module odt_ramp_timer
  import odt_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Control
  input wire logic load,
  input wire logic [3:0] load_val,
  // Status
  output logic expired
);

  typedef struct packed {
    logic [3:0] cnt;
  } timer_state_type;

  timer_state_type st_r;
  timer_state_type st_nxt;

  always_comb
  begin
    st_nxt = st_r;
    if (load)
    begin
      st_nxt.cnt = load_val;
    end
    else if (st_r.cnt != 4'h0)
    begin
      st_nxt.cnt = st_r.cnt - 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign expired = (st_r.cnt == 4'h0) && !load;

endmodule

// ---- tb/odt_ctrl_model.sv ----
// Controller model driving the link clock and the termination control pin
`timescale 1ns/10ps
module odt_ctrl_model (
  // Request from the bench
  input wire logic odt_req,
  // Link pins
  output logic ck_link,
  output logic odt_pin
);
  initial
  begin
    ck_link = 1'b0;
    odt_pin = 1'b0;
  end
  // The controller clock runs free, 64 ns period
  always #32 ck_link = ~ck_link;
  // The one pin is driven from odt_req; changed on the falling edge so it is settled at each rise
  always @(negedge ck_link)
    odt_pin <= odt_req;
endmodule

// ---- tb/test_odt_control.sv ----
// Self-checking testbench for the termination control block
`timescale 1ns/10ps
module test_odt_control;
  import odt_pkg::*;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic odt_req = 1'b0;
  logic ck_link;
  logic odt_pin;
  logic [1:0] org = 2'h0;
  logic [13:0] emr1 = 14'h0000;
  logic [13:0] mr = 14'h0000;
  power_mode_type pmode = 4'h8;
  term_pins_type term_en;
  term_pins_type want;
  logic [1:0] rtt_sel;
  logic term_ramping;
  logic async_mode;
  logic ramp_seen = 1'b0;
  logic async_seen = 1'b0;
  logic [7:0] lfsr = 8'h36;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  int n;

  odt_ctrl_model odt_ctrl_model_inst (.odt_req(odt_req), .ck_link(ck_link), .odt_pin(odt_pin));
  odt_control odt_control_inst (.clk_sys(clk_sys), .rst_n(rst_n), .ck_link(ck_link), .odt_pin(odt_pin),
    .org(org), .emr1(emr1), .mr(mr), .pmode(pmode), .term_en(term_en), .rtt_sel(rtt_sel),
    .term_ramping(term_ramping), .async_mode(async_mode));

  always #4 clk_sys = ~clk_sys;

  always @(posedge clk_sys)
  begin
    if (term_ramping === 1'b1)
      ramp_seen <= 1'b1;
    if (async_mode === 1'b1)
      async_seen <= 1'b1;
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t: run did not finish", $time);
      test_done();
    end
  end

  function automatic logic [7:0] next_rnd(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  function automatic term_pins_type exp_mask(input logic [1:0] o, input logic a10, input logic a11);
    term_pins_type m;
    m = '0;
    m.dq = 1'b1;
    m.dqs = 1'b1;
    m.dqs_n = !a10;
    m.dm = (o == ORG_X8) ? !a11 : 1'b1;
    if (o == ORG_X8)
    begin
      m.rdqs = a11;
      m.rdqs_n = a11 && !a10;
    end
    if (o == ORG_X16)
    begin
      m.udqs = 1'b1;
      m.udqs_n = !a10;
      m.udm = 1'b1;
    end
    return m;
  endfunction

  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  task automatic cmp_val(input logic [8:0] got, input logic [8:0] exp);
    checked = checked + 1;
    if (got !== exp)
    begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t: value %h, want %h", $time, got, exp);
    end
  endtask

  task automatic cmp_lat(input int got, input int lo, input int hi);
    checked = checked + 1;
    if (got < lo || got > hi)
    begin
      bad_count = bad_count + 1;
      $display("unexpected at %0t: delay %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // Latency is counted from the pin change, bounded so a dead output cannot hang the run
  // Outputs are read one step after each edge, once that edge's update has landed
  task automatic drive_odt(input logic v, input term_pins_type exp, output int lat);
    int k;
    odt_req = v;
    k = 0;
    while (odt_pin !== v && k < 20)
    begin
      step(1);
      k++;
    end
    lat = 0;
    while (term_en !== exp && lat < 80)
    begin
      step(1);
      lat++;
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    step(8);
    rst_n = 1'b1;
    step(80);
    cmp_val(term_en, '0);
    // Every organisation meets every A10/A11 pair; the termination value is random
    for (int i = 0; i < 12; i++)
    begin
      lfsr = next_rnd(lfsr);
      org = 2'(i % 3);
      emr1 = 14'h0000;
      {emr1[EMR_RDQS_EN_POS], emr1[EMR_NDQS_DIS_POS]} = 2'(i / 3);
      emr1[EMR_RTT_LO_POS] = lfsr[2];
      emr1[EMR_RTT_HI_POS] = lfsr[3] | ~lfsr[2];
      want = exp_mask(org, emr1[EMR_NDQS_DIS_POS], emr1[EMR_RDQS_EN_POS]);
      step(4);
      cmp_val(9'(rtt_sel), {7'h00, emr1[EMR_RTT_HI_POS], emr1[EMR_RTT_LO_POS]});
      drive_odt(1'b1, want, n);
      cmp_val(term_en, want);
      cmp_lat(n, 16, 48);
      cmp_val(9'(term_ramping), 9'h001);
      // Let the turn-on ramp finish so only the turn-off ramp can mark ramp_seen
      step(2);
      ramp_seen = 1'b0;
      drive_odt(1'b0, '0, n);
      cmp_val(term_en, '0);
      cmp_lat(n, 16, 48);
      cmp_val(9'(ramp_seen), 9'h001);
      step(4);
    end
    // Termination disabled, then self-refresh: the pin must be ignored
    emr1 = 14'h0000;
    odt_req = 1'b1;
    step(60);
    cmp_val(term_en, '0);
    cmp_val(9'(rtt_sel), 9'h000);
    odt_req = 1'b0;
    step(30);
    emr1 = 14'h0044;
    org = ORG_X4;
    pmode = 4'hC;
    odt_req = 1'b1;
    step(60);
    cmp_val(term_en, '0);
    odt_req = 1'b0;
    step(30);
    // Slow-exit active and precharge power-down use the asynchronous path
    for (int j = 0; j < 2; j++)
    begin
      pmode = j ? 4'h1 : 4'h2;
      mr[MR_PD_SLOW_POS] = 1'b1;
      step(6);
      cmp_val(9'(async_mode), 9'h001);
      drive_odt(1'b1, exp_mask(ORG_X4, 1'b0, 1'b0), n);
      cmp_lat(n, 1, 12);
      drive_odt(1'b0, '0, n);
      cmp_lat(n, 1, 12);
      step(4);
    end
    // Power-down exit: asynchronous until the exit spacing has passed
    mr[MR_PD_SLOW_POS] = 1'b0;
    pmode = 4'h8;
    step(4);
    cmp_val(9'(async_mode), 9'h001);
    step(100);
    cmp_val(9'(async_mode), 9'h000);
    // Switching just before fast-exit power-down entry falls back briefly
    async_seen = 1'b0;
    drive_odt(1'b1, exp_mask(ORG_X4, 1'b0, 1'b0), n);
    cmp_lat(n, 16, 48);
    cmp_val(9'(async_mode), 9'h000);
    pmode = 4'hA;
    step(40);
    cmp_val(9'(async_seen), 9'h001);
    drive_odt(1'b0, '0, n);
    step(100);
    cmp_val(9'(async_mode), 9'h000);
    test_done();
  end
endmodule
